// *** common/incr_skip_rotate_pkg.sv ***
package incr_skip_rotate_pkg;

   // ----------------------------------------
   // Opcode fields
   // ----------------------------------------
   localparam int INSTR_W = 16;
   localparam int OPC_HI = 15;
   localparam int OPC_LO = 10;
   localparam int DEST_BIT = 9;
   localparam int ACCESS_BIT = 8;
   localparam int FADDR_HI = 7;
   localparam int FADDR_LO = 0;
   localparam int DATA_W = 8;
   localparam int BANK_W = 4;
   localparam int ADDR_W = BANK_W + DATA_W;

   localparam logic [5:0] OPC_INCR_SKIP_ZERO = 6'h0F;
   localparam logic [5:0] OPC_INCR_SKIP_NONZERO = 6'h12;
   localparam logic [5:0] OPC_ROTATE_LEFT_NOCARRY = 6'h11;

   localparam logic DEST_TO_W = 1'b0;
   localparam logic DEST_TO_FILE = 1'b1;
   localparam logic USE_ACCESS_BANK = 1'b0;
   localparam logic USE_BANK_SELECT = 1'b1;

   // ----------------------------------------
   // Access bank layout
   // ----------------------------------------
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

   // ----------------------------------------
   // Data constants
   // ----------------------------------------
   localparam logic [7:0] DATA_ZERO = 8'h00;
   localparam logic [7:0] DATA_ONE = 8'h01;
   localparam logic [7:0] DATA_ALL_ONES = 8'hFF;
   localparam logic [11:0] ADDR_ZERO = 12'h000;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {OP_NONE, OP_INCR_SKIP_ZERO, OP_INCR_SKIP_NONZERO,
                             OP_ROTATE_LEFT} op_t;

   typedef enum logic [1:0] {ST_RUN, ST_DROP_FIRST, ST_DROP_SECOND} skip_state_t;

endpackage

// *** rtl/incr_rotate_alu.sv ***
`timescale 1ns/1ps
module incr_rotate_alu
(
   // Operation and operand
   input wire incr_skip_rotate_pkg::op_t op,
   input wire logic [7:0] operand,
   // Result
   output logic [7:0] result,
   output logic zero,
   output logic negative
);

   always_comb
   begin
      case (op)
         incr_skip_rotate_pkg::OP_ROTATE_LEFT:
         begin
            result = {operand[6:0], operand[7]};
         end
         incr_skip_rotate_pkg::OP_INCR_SKIP_ZERO,
         incr_skip_rotate_pkg::OP_INCR_SKIP_NONZERO:
         begin
            result = 8'(operand + incr_skip_rotate_pkg::DATA_ONE);
         end
         default:
         begin
            result = operand;
         end
      endcase
      zero = (result == incr_skip_rotate_pkg::DATA_ZERO);
      negative = result[7];
   end

endmodule // incr_rotate_alu

// *** rtl/incr_skip_rotate_exec.sv ***
`timescale 1ns/1ps
module incr_skip_rotate_exec
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Fetched instruction stream
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire logic instr_two_word,
   // Bank selection
   input wire logic [3:0] bank_select_reg,
   // Register file read
   output logic [11:0] file_rd_addr,
   input wire logic [7:0] file_rd_data,
   // Register file write
   output logic file_wr_en,
   output logic [11:0] file_wr_addr,
   output logic [7:0] file_wr_data,
   // Working register write
   output logic w_wr_en,
   output logic [7:0] w_wr_data,
   // Status flags
   output logic flag_wr_en,
   output logic flag_n,
   output logic flag_z,
   // Skip indication
   output logic skip_taken,
   output logic nop_cycle
);

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   incr_skip_rotate_pkg::op_t dec_op;
   logic [7:0] dec_faddr;
   logic [3:0] dec_bank;

   always_comb
   begin
      dec_faddr = instr[incr_skip_rotate_pkg::FADDR_HI:incr_skip_rotate_pkg::FADDR_LO];
      case (instr[incr_skip_rotate_pkg::OPC_HI:incr_skip_rotate_pkg::OPC_LO])
         incr_skip_rotate_pkg::OPC_INCR_SKIP_ZERO: dec_op = incr_skip_rotate_pkg::OP_INCR_SKIP_ZERO;
         incr_skip_rotate_pkg::OPC_INCR_SKIP_NONZERO: dec_op = incr_skip_rotate_pkg::OP_INCR_SKIP_NONZERO;
         incr_skip_rotate_pkg::OPC_ROTATE_LEFT_NOCARRY: dec_op = incr_skip_rotate_pkg::OP_ROTATE_LEFT;
         default: dec_op = incr_skip_rotate_pkg::OP_NONE;
      endcase
      if (instr[incr_skip_rotate_pkg::ACCESS_BIT] == incr_skip_rotate_pkg::USE_BANK_SELECT)
      begin
         dec_bank = bank_select_reg;
      end
      else if (dec_faddr < incr_skip_rotate_pkg::ACCESS_SPLIT)
      begin
         dec_bank = incr_skip_rotate_pkg::ACCESS_LOW_BANK;
      end
      else
      begin
         dec_bank = incr_skip_rotate_pkg::ACCESS_HIGH_BANK;
      end
   end

   // ----------------------------------------
   // Execute
   // ----------------------------------------
   logic ex_valid;
   incr_skip_rotate_pkg::op_t ex_op;
   logic ex_dest;
   incr_skip_rotate_pkg::skip_state_t state;
   logic [7:0] alu_result;
   logic alu_zero;
   logic alu_negative;
   logic skip_now;

   incr_rotate_alu u_alu
   (
      .op(ex_op),
      .operand(file_rd_data),
      .result(alu_result),
      .zero(alu_zero),
      .negative(alu_negative)
   );

   always_comb
   begin
      skip_now = ex_valid &&
                 (((ex_op == incr_skip_rotate_pkg::OP_INCR_SKIP_ZERO) && alu_zero) ||
                  ((ex_op == incr_skip_rotate_pkg::OP_INCR_SKIP_NONZERO) && !alu_zero));
   end

   // ----------------------------------------
   // Next values
   // ----------------------------------------
   logic next_ex_valid;
   incr_skip_rotate_pkg::op_t next_ex_op;
   logic next_ex_dest;
   incr_skip_rotate_pkg::skip_state_t next_state;
   logic [11:0] next_file_rd_addr;
   logic next_file_wr_en;
   logic [11:0] next_file_wr_addr;
   logic [7:0] next_file_wr_data;
   logic next_w_wr_en;
   logic [7:0] next_w_wr_data;
   logic next_flag_wr_en;
   logic next_flag_n;
   logic next_flag_z;
   logic next_skip_taken;
   logic next_nop_cycle;
   logic accept;

   always_comb
   begin
      next_state = state;
      next_nop_cycle = 1'b0;
      next_skip_taken = skip_now;
      accept = 1'b0;
      case (state)
         incr_skip_rotate_pkg::ST_RUN:
         begin
            if (skip_now)
            begin
               if (instr_valid)
               begin
                  next_nop_cycle = 1'b1;
                  if (instr_two_word)
                  begin
                     next_state = incr_skip_rotate_pkg::ST_DROP_SECOND;
                  end
               end
               else
               begin
                  next_state = incr_skip_rotate_pkg::ST_DROP_FIRST;
               end
            end
            else
            begin
               accept = instr_valid && (dec_op != incr_skip_rotate_pkg::OP_NONE);
            end
         end
         incr_skip_rotate_pkg::ST_DROP_FIRST:
         begin
            if (instr_valid)
            begin
               next_nop_cycle = 1'b1;
               next_state = instr_two_word ? incr_skip_rotate_pkg::ST_DROP_SECOND :
                                             incr_skip_rotate_pkg::ST_RUN;
            end
         end
         incr_skip_rotate_pkg::ST_DROP_SECOND:
         begin
            if (instr_valid)
            begin
               next_nop_cycle = 1'b1;
               next_state = incr_skip_rotate_pkg::ST_RUN;
            end
         end
         default:
         begin
            next_state = incr_skip_rotate_pkg::ST_RUN;
         end
      endcase

      next_ex_valid = accept;
      next_ex_op = accept ? dec_op : ex_op;
      next_ex_dest = accept ? instr[incr_skip_rotate_pkg::DEST_BIT] : ex_dest;
      next_file_rd_addr = accept ? {dec_bank, dec_faddr} : file_rd_addr;

      next_file_wr_en = ex_valid && (ex_dest == incr_skip_rotate_pkg::DEST_TO_FILE);
      next_w_wr_en = ex_valid && (ex_dest == incr_skip_rotate_pkg::DEST_TO_W);
      next_file_wr_addr = ex_valid ? file_rd_addr : file_wr_addr;
      next_file_wr_data = next_file_wr_en ? alu_result : file_wr_data;
      next_w_wr_data = next_w_wr_en ? alu_result : w_wr_data;

      next_flag_wr_en = ex_valid && (ex_op == incr_skip_rotate_pkg::OP_ROTATE_LEFT);
      next_flag_n = next_flag_wr_en ? alu_negative : flag_n;
      next_flag_z = next_flag_wr_en ? alu_zero : flag_z;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= incr_skip_rotate_pkg::ST_RUN;
         ex_valid <= 1'b0;
         ex_op <= incr_skip_rotate_pkg::OP_NONE;
         ex_dest <= incr_skip_rotate_pkg::DEST_TO_W;
         file_rd_addr <= incr_skip_rotate_pkg::ADDR_ZERO;
         file_wr_en <= 1'b0;
         file_wr_addr <= incr_skip_rotate_pkg::ADDR_ZERO;
         file_wr_data <= incr_skip_rotate_pkg::DATA_ZERO;
         w_wr_en <= 1'b0;
         w_wr_data <= incr_skip_rotate_pkg::DATA_ZERO;
         flag_wr_en <= 1'b0;
         flag_n <= 1'b0;
         flag_z <= 1'b0;
         skip_taken <= 1'b0;
         nop_cycle <= 1'b0;
      end
      else
      begin
         state <= next_state;
         ex_valid <= next_ex_valid;
         ex_op <= next_ex_op;
         ex_dest <= next_ex_dest;
         file_rd_addr <= next_file_rd_addr;
         file_wr_en <= next_file_wr_en;
         file_wr_addr <= next_file_wr_addr;
         file_wr_data <= next_file_wr_data;
         w_wr_en <= next_w_wr_en;
         w_wr_data <= next_w_wr_data;
         flag_wr_en <= next_flag_wr_en;
         flag_n <= next_flag_n;
         flag_z <= next_flag_z;
         skip_taken <= next_skip_taken;
         nop_cycle <= next_nop_cycle;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   sequence ex_incr_s;
      ex_valid && ((ex_op == incr_skip_rotate_pkg::OP_INCR_SKIP_ZERO) ||
                   (ex_op == incr_skip_rotate_pkg::OP_INCR_SKIP_NONZERO));
   endsequence

   sequence skip_two_word_s;
      skip_now && instr_valid && instr_two_word && (state == incr_skip_rotate_pkg::ST_RUN);
   endsequence

   incz_skip_a: assert property (ex_valid && (ex_op == incr_skip_rotate_pkg::OP_INCR_SKIP_ZERO)
      |=> skip_taken == ($past(file_rd_data) == incr_skip_rotate_pkg::DATA_ALL_ONES))
      else $error("zero skip wrong");
   incnz_skip_a: assert property (ex_valid && (ex_op == incr_skip_rotate_pkg::OP_INCR_SKIP_NONZERO)
      |=> skip_taken == ($past(file_rd_data) != incr_skip_rotate_pkg::DATA_ALL_ONES))
      else $error("nonzero skip wrong");
   incr_data_a: assert property (ex_incr_s
      |=> ((file_wr_en ? file_wr_data : w_wr_data) ==
           8'($past(file_rd_data) + incr_skip_rotate_pkg::DATA_ONE)))
      else $error("increment result wrong");
   dest_select_a: assert property (ex_valid |=> (file_wr_en != w_wr_en) &&
      (file_wr_en == ($past(ex_dest) == incr_skip_rotate_pkg::DEST_TO_FILE)))
      else $error("destination wrong");
   bank_select_a: assert property (accept && instr[incr_skip_rotate_pkg::ACCESS_BIT]
      |=> file_rd_addr == {$past(bank_select_reg),
          $past(instr[incr_skip_rotate_pkg::FADDR_HI:incr_skip_rotate_pkg::FADDR_LO])})
      else $error("bank select address wrong");
   access_bank_a: assert property (accept && !instr[incr_skip_rotate_pkg::ACCESS_BIT]
      |=> file_rd_addr[11:8] == ($past(instr[incr_skip_rotate_pkg::FADDR_HI]) ?
          incr_skip_rotate_pkg::ACCESS_HIGH_BANK : incr_skip_rotate_pkg::ACCESS_LOW_BANK))
      else $error("access bank address wrong");
   skip_nop_a: assert property (skip_now |=> skip_taken && !ex_valid && $stable(file_rd_addr))
      else $error("skip did not suppress execution");
   one_word_nop_a: assert property (skip_now && instr_valid && !instr_two_word
      |=> nop_cycle && (state == incr_skip_rotate_pkg::ST_RUN))
      else $error("single nop missing");
   two_word_nop_a: assert property (skip_two_word_s ##1 instr_valid
      |-> nop_cycle ##1 (nop_cycle && (state == incr_skip_rotate_pkg::ST_RUN)))
      else $error("two word skip not three cycles");
   rotate_a: assert property (ex_valid && (ex_op == incr_skip_rotate_pkg::OP_ROTATE_LEFT)
      |=> flag_wr_en && (flag_n == $past(file_rd_data[6])) &&
          (flag_z == ($past(file_rd_data) == incr_skip_rotate_pkg::DATA_ZERO)) &&
          ((file_wr_en ? file_wr_data : w_wr_data) ==
           {$past(file_rd_data[6:0]), $past(file_rd_data[7])}))
      else $error("rotate result or flags wrong");
   incr_flags_a: assert property (ex_incr_s |=> !flag_wr_en)
      else $error("increment touched flags");
   single_cycle_a: assert property (accept |=> ex_valid ##1 (file_wr_en || w_wr_en))
      else $error("instruction not one cycle");

endmodule // incr_skip_rotate_exec

// *** test/regfile_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Data register file seen by the block.
// ----------------------------------------
module regfile_model
(
   // Clock
   input wire logic clk_sys,
   // Read port
   input wire logic [11:0] file_rd_addr,
   output logic [7:0] file_rd_data,
   // Write port
   input wire logic file_wr_en,
   input wire logic [11:0] file_wr_addr,
   input wire logic [7:0] file_wr_data
);
   logic [7:0] mem [0:4095];
   // Reads return the addressed cell at once, with no hold of an older value.
   assign file_rd_data = mem[file_rd_addr];
   always @(posedge clk_sys)
   begin
      if (file_wr_en)
      begin
         mem[file_wr_addr] <= file_wr_data;
      end
   end
   task automatic load(input logic [11:0] a, input logic [7:0] d);
      mem[a] = d;
   endtask
endmodule // regfile_model

// *** test/test_incr_skip_rotate_exec.sv ***
`timescale 1ns/1ps
module test_incr_skip_rotate_exec;
   logic clk_sys;
   logic arst_n;
   logic instr_valid;
   logic [15:0] instr;
   logic instr_two_word;
   logic [3:0] bank_select_reg;
   logic [11:0] file_rd_addr;
   logic [7:0] file_rd_data;
   logic file_wr_en;
   logic [11:0] file_wr_addr;
   logic [7:0] file_wr_data;
   logic w_wr_en;
   logic [7:0] w_wr_data;
   logic flag_wr_en;
   logic flag_n;
   logic flag_z;
   logic skip_taken;
   logic nop_cycle;
   int error_cnt;
   int compares;
   logic [11:0] c1_addr, c2_waddr;
   logic [7:0] c2_fdat, c2_wdat, c3_wdat;
   logic c2_wr, c2_w, c2_fl, c2_n, c2_z, c2_skip, c2_nop, c3_w, c3_nop, c4_w, c4_nop;
   // Follower word: rotate of access cell 0x01 into the working register.
   localparam logic [15:0] FOLLOW = 16'h4401;
   incr_skip_rotate_exec DUT (.clk_sys(clk_sys), .arst_n(arst_n),
      .instr_valid(instr_valid), .instr(instr), .instr_two_word(instr_two_word),
      .bank_select_reg(bank_select_reg), .file_rd_addr(file_rd_addr),
      .file_rd_data(file_rd_data), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
      .file_wr_data(file_wr_data), .w_wr_en(w_wr_en), .w_wr_data(w_wr_data),
      .flag_wr_en(flag_wr_en), .flag_n(flag_n), .flag_z(flag_z),
      .skip_taken(skip_taken), .nop_cycle(nop_cycle));
   regfile_model partner (.clk_sys(clk_sys), .file_rd_addr(file_rd_addr),
      .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
      .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data));
   // ----------------------------------------
   // Helpers.
   // ----------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      compares++;
      if (g !== e)
      begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   function automatic logic [15:0] enc(logic [5:0] op, logic d, logic a, logic [7:0] f);
      return {op, d, a, f};
   endfunction
   // Presents one word, the follower in the next cycle, and records four cycles.
   task automatic exec(input logic [15:0] w, input logic [3:0] b, input logic two);
      instr = w;
      instr_valid = 1'b1;
      bank_select_reg = b;
      instr_two_word = 1'b0;
      @(posedge clk_sys);
      #1;
      c1_addr = file_rd_addr;
      instr = FOLLOW;
      instr_two_word = two;
      @(posedge clk_sys);
      #1;
      {c2_wr, c2_waddr, c2_fdat, c2_w, c2_wdat} = {file_wr_en, file_wr_addr,
         file_wr_data, w_wr_en, w_wr_data};
      {c2_fl, c2_n, c2_z, c2_skip, c2_nop} = {flag_wr_en, flag_n, flag_z, skip_taken,
         nop_cycle};
      instr_two_word = 1'b0;
      instr_valid = two;
      @(posedge clk_sys);
      #1;
      {c3_w, c3_wdat, c3_nop} = {w_wr_en, w_wr_data, nop_cycle};
      instr_valid = 1'b0;
      @(posedge clk_sys);
      #1;
      {c4_w, c4_nop} = {w_wr_en, nop_cycle};
      @(posedge clk_sys);
      #1;
   endtask
   // ----------------------------------------
   // Scenarios.
   // ----------------------------------------
   task automatic t_zero_skip();
      partner.load(12'h310, 8'hFF);
      exec(enc(incr_skip_rotate_pkg::OPC_INCR_SKIP_ZERO, 1'b1, 1'b1, 8'h10), 4'h3, 1'b0);
      chk("rd_addr", 12'h310, c1_addr);
      chk("wr_en", 1'b1, c2_wr);
      chk("wr_addr", 12'h310, c2_waddr);
      chk("wr_data", 8'h00, c2_fdat);
      chk("w_en", 1'b0, c2_w);
      chk("flag_en", 1'b0, c2_fl);
      chk("skip", 1'b1, c2_skip);
      chk("nop", 1'b1, c2_nop);
      chk("follow_w", 1'b0, c3_w);
      chk("nop3", 1'b0, c3_nop);
   endtask
   task automatic t_zero_run();
      partner.load(12'hF85, 8'h41);
      exec(enc(incr_skip_rotate_pkg::OPC_INCR_SKIP_ZERO, 1'b0, 1'b0, 8'h85), 4'h5, 1'b0);
      chk("rd_addr", 12'hF85, c1_addr);
      chk("w_data", 8'h42, c2_wdat);
      chk("wr_en", 1'b0, c2_wr);
      chk("skip", 1'b0, c2_skip);
      chk("flag_en", 1'b0, c2_fl);
      chk("follow_w", 1'b1, c3_w);
      chk("follow_d", 8'h03, c3_wdat);
   endtask
   task automatic t_nonzero_two();
      partner.load(12'h020, 8'h05);
      exec(enc(incr_skip_rotate_pkg::OPC_INCR_SKIP_NONZERO, 1'b1, 1'b0, 8'h20), 4'h7, 1'b1);
      chk("wr_addr", 12'h020, c2_waddr);
      chk("wr_data", 8'h06, c2_fdat);
      chk("skip", 1'b1, c2_skip);
      chk("flag_en", 1'b0, c2_fl);
      chk("nop", 1'b1, c2_nop);
      chk("nop3", 1'b1, c3_nop);
      chk("w3", 1'b0, c3_w);
      chk("w4", 1'b0, c4_w);
      chk("nop4", 1'b0, c4_nop);
   endtask
   task automatic t_nonzero_run();
      partner.load(12'h7FF, 8'hFF);
      exec(enc(incr_skip_rotate_pkg::OPC_INCR_SKIP_NONZERO, 1'b0, 1'b1, 8'hFF), 4'h7, 1'b0);
      chk("rd_addr", 12'h7FF, c1_addr);
      chk("w_data", 8'h00, c2_wdat);
      chk("skip", 1'b0, c2_skip);
      chk("nop", 1'b0, c2_nop);
      chk("follow_w", 1'b1, c3_w);
   endtask
   task automatic t_rotate();
      logic [7:0] rin [3] = '{8'hAB, 8'h00, 8'h40};
      logic [7:0] rout [3] = '{8'h57, 8'h00, 8'h80};
      logic rn [3] = '{1'b0, 1'b0, 1'b1};
      logic rz [3] = '{1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 3; i++)
      begin
         partner.load(12'hA30, rin[i]);
         exec(enc(incr_skip_rotate_pkg::OPC_ROTATE_LEFT_NOCARRY, 1'b1, 1'b1, 8'h30), 4'hA,
            1'b0);
         chk("wr_data", rout[i], c2_fdat);
         chk("wr_addr", 12'hA30, c2_waddr);
         chk("flag_en", 1'b1, c2_fl);
         chk("flag_n", rn[i], c2_n);
         chk("flag_z", rz[i], c2_z);
         chk("skip", 1'b0, c2_skip);
         chk("follow_w", 1'b1, c3_w);
      end
   endtask
   // Skip with no word in the skip cycle, then a two-word drop and an unknown opcode.
   task automatic t_gap_skip();
      partner.load(12'h042, 8'hFF);
      instr = enc(incr_skip_rotate_pkg::OPC_INCR_SKIP_ZERO, 1'b0, 1'b0, 8'h42);
      instr_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      instr_valid = 1'b0;
      @(posedge clk_sys);
      #1;
      chk("gap_skip", 1'b1, skip_taken);
      chk("gap_w", 8'h00, w_wr_data);
      chk("gap_nop", 1'b0, nop_cycle);
      instr = FOLLOW;
      instr_valid = 1'b1;
      instr_two_word = 1'b1;
      @(posedge clk_sys);
      #1;
      chk("drop1", 1'b1, nop_cycle);
      instr_two_word = 1'b0;
      @(posedge clk_sys);
      #1;
      chk("drop2", 1'b1, nop_cycle);
      chk("drop2_w", 1'b0, w_wr_en);
      instr = 16'hFFFF;
      @(posedge clk_sys);
      #1;
      chk("bad_op_nop", 1'b0, nop_cycle);
      instr = FOLLOW;
      @(posedge clk_sys);
      #1;
      chk("bad_op_out", 3'h0, {file_wr_en, w_wr_en, flag_wr_en});
      instr_valid = 1'b0;
      @(posedge clk_sys);
      #1;
      chk("after_w", 1'b1, w_wr_en);
      chk("after_d", 8'h03, w_wr_data);
   endtask
   // ----------------------------------------
   // Main sequence.
   // ----------------------------------------
   initial
   begin
      {arst_n, instr_valid, instr, instr_two_word, bank_select_reg} = '0;
      error_cnt = 0;
      compares = 0;
      partner.load(12'h001, 8'h81);
      repeat (12) @(posedge clk_sys);
      #1;
      arst_n = 1'b1;
      @(posedge clk_sys);
      #1;
      chk("idle", 12'h000, {file_wr_en, w_wr_en, flag_wr_en, skip_taken, nop_cycle});
      t_zero_skip();
      t_zero_run();
      t_nonzero_two();
      t_nonzero_run();
      t_rotate();
      t_gap_skip();
      end_of_test();
   end
   initial
   begin
      repeat (4000) @(posedge clk_sys);
      error_cnt++;
      end_of_test();
   end
endmodule // test_incr_skip_rotate_exec
